// *** design/vic_defs.vh ***
// Constants for the vectored interrupt controller: offsets, fields, vectors.
// Assumes inclusion by the controller module only.
`ifndef VIC_DEFS_VH
`define VIC_DEFS_VH
`define VIC_ADDR_W          8
// Printed offsets are indexes; byte address is four times the index.
`define VIC_IDX_CTRL_LO     8'h0b
`define VIC_IDX_CTRL_HI     8'h1e
`define VIC_IDX_IRQ_STAT    8'h20
`define VIC_IDX_IRQ_MASK    8'h21
`define VIC_IDX_EDGE_SEL    8'h22
`define VIC_IDX_CORE_STAT   8'h23
`define VIC_LO_GIE          0
`define VIC_LO_EA_EN        1
`define VIC_LO_EB_EN        2
`define VIC_LO_TMR_EN       3
`define VIC_LO_EA_FLAG      4
`define VIC_LO_EB_FLAG      5
`define VIC_LO_TMR_FLAG     6
`define VIC_HI_TICK_EN      0
`define VIC_HI_RTC_EN       1
`define VIC_HI_TICK_FLAG    4
`define VIC_HI_RTC_FLAG     5
`define VIC_LO_RW_MASK      8'h7f
`define VIC_HI_RW_MASK      8'h33
`define VIC_LO_RESET        8'h00
`define VIC_HI_RESET        8'h00
`define VIC_EDGE_RESET      4'h5
`define VIC_EDGE_FALL       2'h1
`define VIC_EDGE_RISE       2'h2
`define VIC_EDGE_BOTH       2'h3
`define VIC_VEC_EXT_A       8'h04
`define VIC_VEC_EXT_B       8'h08
`define VIC_VEC_TIMER       8'h0c
`define VIC_VEC_TICK        8'h10
`define VIC_VEC_RTC         8'h14
`define VIC_RESP_OKAY       2'h0
`define VIC_RESP_SLVERR     2'h2
`endif

// *** design/vic_ctrl.v ***
// Vectored interrupt controller with an AXI4-Lite register slave.
// Assumes a core that pulses ACK_TAKEN after pushing PC and RETURN_FROM_IRQ_DONE on return.
// Summary of operation
// - External pin edge of selected polarity sets its external request flag.
// - Enabled external flag with stack room branches to 04H or 08H, clearing flag, global.
// - Timer overflow sets timer flag; service branches to 0CH clearing flag and global.
// - Each time base tick sets tick flag in upper register bit 4.
// - Upper register bit 5 holds real time clock flag, one while pending.
// - With global enable off, requests are not taken but flags still set.
// - Software re-setting global and source enable inside a routine allows nesting.
// - No request is acknowledged while the return stack is full.
// - Every interrupt source can wake the device from power-down.
// - Acknowledge pushes only the program counter, then branches to the vector.
// - Lower register bits 0..3: global, external a, external b, timer enables.
// - Upper register bits 0 and 1 enable tick and real time clock.
// - Enabled tick flag with stack room branches to 10H, clears flag and global.
// - Enabled clock flag with stack room branches to 14H, clears flag and global.
// - Simultaneous requests served in order ext a, ext b, timer, tick, clock.
// - Return from interrupt sets global enable; plain return leaves it.
//
// Implementation choice: register access over AXI4-Lite.
`include "vic_defs.vh"
module vic_ctrl #(
  parameter AW = `VIC_ADDR_W + 2
) (
  input  wire          CLK,
  input  wire          RSTN,
  input  wire [AW-1:0] S_AXI_AWADDR,
  input  wire          S_AXI_AWVALID,
  output reg           S_AXI_AWREADY,
  input  wire [31:0]   S_AXI_WDATA,
  input  wire [3:0]    S_AXI_WSTRB,
  input  wire          S_AXI_WVALID,
  output reg           S_AXI_WREADY,
  output reg  [1:0]    S_AXI_BRESP,
  output reg           S_AXI_BVALID,
  input  wire          S_AXI_BREADY,
  input  wire [AW-1:0] S_AXI_ARADDR,
  input  wire          S_AXI_ARVALID,
  output reg           S_AXI_ARREADY,
  output reg  [31:0]   S_AXI_RDATA,
  output reg  [1:0]    S_AXI_RRESP,
  output reg           S_AXI_RVALID,
  input  wire          S_AXI_RREADY,
  input  wire          EXT_IRQ_A_PIN,
  input  wire          EXT_IRQ_B_PIN,
  input  wire          TIMER_OVF,
  input  wire          TICK,
  input  wire          RTC_TICK,
  input  wire          STACK_FULL,
  input  wire          ACK_TAKEN,
  input  wire          RETURN_FROM_IRQ_DONE,
  output reg           IRQ_REQ,
  output reg  [7:0]    IRQ_VECTOR,
  output reg           WAKE,
  output reg           IRQ
);

  function edge_hit;
    input [1:0] sel;
    input       prev;
    input       cur;
    begin
      edge_hit = (sel[0] & prev & ~cur) | (sel[1] & ~prev & cur);
    end
  endfunction

  function [7:0] vec_of;
    input [4:0] p;
    begin
      if (p[0]) begin
        vec_of = `VIC_VEC_EXT_A;
      end else if (p[1]) begin
        vec_of = `VIC_VEC_EXT_B;
      end else if (p[2]) begin
        vec_of = `VIC_VEC_TIMER;
      end else if (p[3]) begin
        vec_of = `VIC_VEC_TICK;
      end else begin
        vec_of = `VIC_VEC_RTC;
      end
    end
  endfunction

  reg  [1:0]  sync_a_q;
  reg  [1:0]  sync_b_q;
  reg         prev_a_q;
  reg         prev_b_q;
  reg  [6:0]  lo_q;
  reg  [5:0]  hi_q;
  reg  [3:0]  edge_sel_q;
  reg  [4:0]  stat_q;
  reg  [4:0]  mask_q;
  reg         aw_got_q;
  reg         w_got_q;
  reg  [AW-1:0] awaddr_q;
  reg  [31:0] wdata_q;
  reg  [3:0]  wstrb_q;

  // Masks and reset values as 8-bit parameters, so only implemented bits are taken.
  localparam [7:0] LO_MASK = `VIC_LO_RW_MASK;
  localparam [7:0] HI_MASK = `VIC_HI_RW_MASK;
  localparam [7:0] LO_INIT = `VIC_LO_RESET;
  localparam [7:0] HI_INIT = `VIC_HI_RESET;

  wire          ev_a;
  wire          ev_b;
  wire [4:0]    events;
  wire [4:0]    flags;
  wire [4:0]    enables;
  wire [4:0]    pend;
  wire          req_d;
  wire [4:0]    grant;
  wire [4:0]    taken;
  wire          wr_fire;
  wire [AW-3:0] widx;
  wire [AW-3:0] ridx;
  wire          wr_lo;
  wire          wr_hi;
  wire          rd_fire;
  wire          rd_stat;

  assign ev_a    = edge_hit(edge_sel_q[1:0], prev_a_q, sync_a_q[1]);
  assign ev_b    = edge_hit(edge_sel_q[3:2], prev_b_q, sync_b_q[1]);
  assign events  = {RTC_TICK, TICK, TIMER_OVF, ev_b, ev_a};
  assign flags   = {hi_q[`VIC_HI_RTC_FLAG], hi_q[`VIC_HI_TICK_FLAG],
                    lo_q[`VIC_LO_TMR_FLAG], lo_q[`VIC_LO_EB_FLAG],
                    lo_q[`VIC_LO_EA_FLAG]};
  assign enables = {hi_q[`VIC_HI_RTC_EN], hi_q[`VIC_HI_TICK_EN],
                    lo_q[`VIC_LO_TMR_EN], lo_q[`VIC_LO_EB_EN], lo_q[`VIC_LO_EA_EN]};
  assign pend    = flags & enables;
  assign req_d   = lo_q[`VIC_LO_GIE] & ~STACK_FULL & (|pend);
  // Lowest set bit wins: source a has the highest priority.
  assign grant   = pend & ~(pend - 5'h01);
  assign taken   = (ACK_TAKEN & IRQ_REQ) ? grant : 5'h00;
  assign wr_fire = aw_got_q & w_got_q & ~S_AXI_BVALID;
  assign widx    = awaddr_q[AW-1:2];
  assign ridx    = S_AXI_ARADDR[AW-1:2];
  assign wr_lo   = wr_fire & (widx == `VIC_IDX_CTRL_LO) & wstrb_q[0];
  assign wr_hi   = wr_fire & (widx == `VIC_IDX_CTRL_HI) & wstrb_q[0];
  assign rd_fire = S_AXI_ARVALID & S_AXI_ARREADY;
  assign rd_stat = rd_fire & (ridx == `VIC_IDX_IRQ_STAT);
  reg  [4:0]  flag_d;
  reg  [6:0]  lo_d;
  reg  [5:0]  hi_d;
  reg  [31:0] rdata_d;
  reg         rok_d;
  reg         wok_d;

  always @* begin
    lo_d = lo_q;
    hi_d = hi_q;
    if (wr_lo) begin
      lo_d = wdata_q[6:0] & LO_MASK[6:0];
    end
    if (wr_hi) begin
      hi_d = wdata_q[5:0] & HI_MASK[5:0];
    end
    flag_d = {hi_d[`VIC_HI_RTC_FLAG], hi_d[`VIC_HI_TICK_FLAG], lo_d[`VIC_LO_TMR_FLAG],
              lo_d[`VIC_LO_EB_FLAG], lo_d[`VIC_LO_EA_FLAG]};
    // Service clears its flag, but a new event in the same cycle keeps it set.
    flag_d = (flag_d & ~taken) | events;
    if (|taken) begin
      lo_d[`VIC_LO_GIE] = 1'b0;
    end
    if (RETURN_FROM_IRQ_DONE) begin
      lo_d[`VIC_LO_GIE] = 1'b1;
    end
    lo_d[`VIC_LO_EA_FLAG]   = flag_d[0];
    lo_d[`VIC_LO_EB_FLAG]   = flag_d[1];
    lo_d[`VIC_LO_TMR_FLAG]  = flag_d[2];
    hi_d[`VIC_HI_TICK_FLAG] = flag_d[3];
    hi_d[`VIC_HI_RTC_FLAG]  = flag_d[4];
  end

  always @* begin
    rdata_d = 32'h0000_0000;
    rok_d   = 1'b1;
    case (ridx)
      `VIC_IDX_CTRL_LO: begin
        rdata_d[6:0] = lo_q;
      end
      `VIC_IDX_CTRL_HI: begin
        rdata_d[5:0] = hi_q & HI_MASK[5:0];
      end
      `VIC_IDX_IRQ_STAT: begin
        rdata_d[4:0] = stat_q;
      end
      `VIC_IDX_IRQ_MASK: begin
        rdata_d[4:0] = mask_q;
      end
      `VIC_IDX_EDGE_SEL: begin
        rdata_d[3:0] = edge_sel_q;
      end
      `VIC_IDX_CORE_STAT: begin
        rdata_d[1:0] = {STACK_FULL, IRQ_REQ};
      end
      default: begin
        rok_d = 1'b0;
      end
    endcase
  end

  always @* begin
    case (widx)
      `VIC_IDX_CTRL_LO, `VIC_IDX_CTRL_HI, `VIC_IDX_IRQ_STAT,
      `VIC_IDX_IRQ_MASK, `VIC_IDX_EDGE_SEL, `VIC_IDX_CORE_STAT: wok_d = 1'b1;
      default: wok_d = 1'b0;
    endcase
  end

  // The pins idle high, so the synchroniser starts high to avoid a false edge.
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      sync_a_q <= 2'h3;
      sync_b_q <= 2'h3;
      prev_a_q <= 1'b1;
      prev_b_q <= 1'b1;
    end else begin
      sync_a_q <= {sync_a_q[0], EXT_IRQ_A_PIN};
      sync_b_q <= {sync_b_q[0], EXT_IRQ_B_PIN};
      prev_a_q <= sync_a_q[1];
      prev_b_q <= sync_b_q[1];
    end
  end

  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      lo_q       <= LO_INIT[6:0];
      hi_q       <= HI_INIT[5:0];
      edge_sel_q <= `VIC_EDGE_RESET;
      mask_q     <= 5'h00;
    end else begin
      lo_q <= lo_d;
      hi_q <= hi_d;
      if (wr_fire & wstrb_q[0] & (widx == `VIC_IDX_IRQ_MASK)) begin
        mask_q <= wdata_q[4:0];
      end
      if (wr_fire & wstrb_q[0] & (widx == `VIC_IDX_EDGE_SEL)) begin
        edge_sel_q <= wdata_q[3:0];
      end
    end
  end

  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      IRQ_REQ    <= 1'b0;
      IRQ_VECTOR <= 8'h00;
      WAKE       <= 1'b0;
    end else begin
      // Core request and vector; the core pushes only PC on ACK_TAKEN.
      IRQ_REQ    <= req_d & ~(|taken);
      IRQ_VECTOR <= vec_of(grant);
      WAKE       <= |flag_d;
    end
  end

  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      stat_q <= 5'h00;
      IRQ    <= 1'b0;
    end else begin
      // Sticky event status; a read clears it but a same-cycle event wins.
      stat_q <= ((rd_stat ? 5'h00 : stat_q) | events);
      IRQ    <= |(((rd_stat ? 5'h00 : stat_q) | events) & mask_q);
    end
  end

  // Write channel: address and data accepted in either order.
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      aw_got_q      <= 1'b0;
      w_got_q       <= 1'b0;
      awaddr_q      <= {AW{1'b0}};
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= `VIC_RESP_OKAY;
    end else begin
      S_AXI_AWREADY <= ~aw_got_q & ~S_AXI_AWREADY & S_AXI_AWVALID;
      S_AXI_WREADY  <= ~w_got_q & ~S_AXI_WREADY & S_AXI_WVALID;
      if (S_AXI_AWVALID & S_AXI_AWREADY) begin
        aw_got_q <= 1'b1;
        awaddr_q <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID & S_AXI_WREADY) begin
        w_got_q <= 1'b1;
        wdata_q <= S_AXI_WDATA;
        wstrb_q <= S_AXI_WSTRB;
      end
      if (wr_fire) begin
        aw_got_q     <= 1'b0;
        w_got_q      <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= wok_d ? `VIC_RESP_OKAY : `VIC_RESP_SLVERR;
      end else if (S_AXI_BVALID & S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // Read channel: one outstanding read.
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0000_0000;
      S_AXI_RRESP   <= `VIC_RESP_OKAY;
    end else begin
      S_AXI_ARREADY <= ~S_AXI_ARREADY & ~S_AXI_RVALID & S_AXI_ARVALID;
      if (rd_fire) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA  <= rdata_d;
        S_AXI_RRESP  <= rok_d ? `VIC_RESP_OKAY : `VIC_RESP_SLVERR;
      end else if (S_AXI_RVALID & S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

endmodule // vic_ctrl

// *** tb/vic_ctrl_sva.sv ***
// Checker for the controller ports: bus answers and the request to the core.
// Bound into every vic_ctrl instance; sees only its ports.
module vic_ctrl_sva (
  input logic        CLK,
  input logic        RSTN,
  input logic [1:0]  S_AXI_BRESP,
  input logic        S_AXI_BVALID,
  input logic        S_AXI_BREADY,
  input logic [31:0] S_AXI_RDATA,
  input logic        S_AXI_RVALID,
  input logic        S_AXI_RREADY,
  input logic        STACK_FULL,
  input logic        ACK_TAKEN,
  input logic        RETURN_FROM_IRQ_DONE,
  input logic        IRQ_REQ,
  input logic [7:0]  IRQ_VECTOR,
  input logic        WAKE,
  input logic        IRQ
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  a_full_blocks_req:
    assert property (STACK_FULL |=> !IRQ_REQ) else $error("request with stack full");
  a_ack_drops_req:
    assert property (ACK_TAKEN && IRQ_REQ && !RETURN_FROM_IRQ_DONE |-> ##[1:2] !IRQ_REQ)
    else $error("request kept after ack");
  a_vector_legal:
    assert property (IRQ_REQ |-> IRQ_VECTOR inside {8'h04, 8'h08, 8'h0c, 8'h10, 8'h14})
    else $error("illegal vector");
  a_req_needs_wake:
    assert property (IRQ_REQ && !$past(ACK_TAKEN) |-> WAKE) else $error("request without wake");
  a_bresp_holds:
    assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write answer dropped");
  a_rdata_holds:
    assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read answer dropped");
  a_unused_zero:
    assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h0) else $error("upper bits set");
  a_reset_quiet:
    assert property ($rose(RSTN) |-> !IRQ_REQ && !IRQ && !WAKE && !S_AXI_BVALID)
    else $error("output active after reset");
endmodule // vic_ctrl_sva
bind vic_ctrl vic_ctrl_sva i_vic_ctrl_sva (.CLK, .RSTN, .S_AXI_BRESP, .S_AXI_BVALID,
  .S_AXI_BREADY, .S_AXI_RDATA, .S_AXI_RVALID, .S_AXI_RREADY, .STACK_FULL, .ACK_TAKEN,
  .RETURN_FROM_IRQ_DONE, .IRQ_REQ, .IRQ_VECTOR, .WAKE, .IRQ);

// *** tb/vic_core_model.sv ***
// Core model: takes requests, logs vectors, returns after a short routine.
// Assumes the controller's level request and one-cycle ack and return pulses.
module vic_core_model (
  input  logic        clk,
  input  logic        rst_n,
  input  logic        irq_req,
  input  logic [7:0]  irq_vector,
  input  logic        hold_full,
  output logic        stack_full,
  output logic        ack_taken,
  output logic        return_from_irq_done,
  output logic [3:0]  ack_cnt,
  output logic [39:0] vec_log
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] busy;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {stack_full, ack_taken, return_from_irq_done, ack_cnt, vec_log, busy} <= '0;
    end else begin
      ack_taken  <= 1'b0;
      stack_full <= hold_full;
      return_from_irq_done  <= (busy == 3'h1);
      if (busy != 3'h0) begin
        busy <= busy - 3'h1;
      end else if (irq_req && !stack_full) begin
        ack_taken <= 1'b1;
        ack_cnt   <= ack_cnt + 4'h1;
        vec_log   <= {vec_log[31:0], irq_vector};
        busy      <= 3'h6;
      end
    end
  end
endmodule // vic_core_model

// *** tb/vic_ctrl_tb_top.sv ***
// Testbench for the controller: register bus tasks and a core model.
// Assumes the design under design/ and the core model file.
module vic_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [9:0] lo_a = 10'h02c, hi_a = 10'h078, st_a = 10'h080, mk_a = 10'h084;
  logic        clk = 0, rst_n = 0, hold = 1, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic [9:0]  awa = 0, ara = 0;
  logic [31:0] wd = 0, rdt, d;
  logic [1:0]  pins = 2'h3, bresp, rresp, r;
  logic [2:0]  ev = 0;
  logic        awr, wr_r, bv, arr, rv, req, wake, irq, full, ack, return_from_irq;
  logic [7:0]  vec;
  logic [3:0]  acks;
  logic [39:0] vlog;
  int          miscompares = 0, total_checks = 0;
  always #5 clk = ~clk;
  vic_ctrl i_vic_ctrl (.CLK(clk), .RSTN(rst_n), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wr_r), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(br),
    .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdt),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr), .EXT_IRQ_A_PIN(pins[0]),
    .EXT_IRQ_B_PIN(pins[1]), .TIMER_OVF(ev[0]), .TICK(ev[1]), .RTC_TICK(ev[2]),
    .STACK_FULL(full), .ACK_TAKEN(ack), .RETURN_FROM_IRQ_DONE(return_from_irq), .IRQ_REQ(req), .IRQ_VECTOR(vec),
    .WAKE(wake), .IRQ(irq));
  vic_core_model i_vic_core_model (.clk(clk), .rst_n(rst_n), .irq_req(req), .irq_vector(vec),
    .hold_full(hold), .stack_full(full), .ack_taken(ack), .return_from_irq_done(return_from_irq), .ack_cnt(acks),
    .vec_log(vlog));
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic hang;
    miscompares++;
    summarize;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Handshake signals are sampled mid-cycle and acted on at the next rising edge.
  task automatic wr(input logic [9:0] a, input logic [31:0] dt);
    bit aw, w, b;
    @(posedge clk);
    awa <= a;
    wd  <= dt;
    awv <= 1;
    wv  <= 1;
    br  <= 1;
    for (int i = 0; i < 50; i++) begin
      @(negedge clk);
      {aw, w, b, r} = {awr, wr_r, bv, bresp};
      @(posedge clk);
      if (aw) awv <= 0;
      if (w) wv <= 0;
      if (b) begin
        br <= 0;
        return;
      end
    end
    hang;
  endtask
  task automatic rd(input logic [9:0] a);
    bit ar, v;
    @(posedge clk);
    ara <= a;
    arv <= 1;
    rr  <= 1;
    for (int i = 0; i < 50; i++) begin
      @(negedge clk);
      {ar, v, d, r} = {arr, rv, rdt, rresp};
      @(posedge clk);
      if (ar) arv <= 0;
      if (v) begin
        rr <= 0;
        return;
      end
    end
    hang;
  endtask
  task automatic rdc(input logic [9:0] a, input logic [7:0] e);
    rd(a);
    chk(d, e);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1;
    rdc(lo_a, 8'h00);
    rdc(hi_a, 8'h00);
    rdc(10'h088, 8'h05);
    rd(10'h000);
    chk(r, 2'h2);
    $display("test reset done");
    wr(lo_a, 32'hff);
    rdc(lo_a, 8'h7f);
    wr(hi_a, 32'hff);
    rdc(hi_a, 8'h33);
    wr(lo_a, 32'h0);
    wr(hi_a, 32'h0);
    wr(10'h3fc, 32'h1);
    chk(r, 2'h2);
    rd(st_a);
    $display("test fields done");
    @(posedge clk);
    ev <= 3'h7;
    @(posedge clk);
    ev <= 3'h0;
    cyc(3);
    rdc(lo_a, 8'h40);
    rdc(hi_a, 8'h30);
    cyc(1);
    chk(wake, 1'b1);
    chk(irq, 1'b0);
    wr(mk_a, 32'h04);
    cyc(2);
    chk(irq, 1'b1);
    rdc(st_a, 8'h1c);
    cyc(2);
    chk(irq, 1'b0);
    $display("test events done");
    wr(lo_a, 32'h0e);
    wr(hi_a, 32'h03);
    @(posedge clk);
    pins <= 2'h0;
    ev   <= 3'h7;
    @(posedge clk);
    ev <= 3'h0;
    cyc(6);
    rdc(lo_a, 8'h7e);
    rdc(hi_a, 8'h33);
    wr(lo_a, 32'h7f);
    cyc(10);
    chk(acks, 4'h0);
    @(posedge clk);
    hold <= 0;
    for (int i = 0; i < 300 && acks != 4'h5; i++) @(negedge clk);
    if (acks !== 4'h5) hang;
    chk(vlog, 40'h04080c1014);
    cyc(12);
    rdc(lo_a, 8'h0f);
    rdc(hi_a, 8'h03);
    $display("test service done");
    wr(lo_a, 32'h0);
    wr(10'h088, 32'h0b);
    rdc(10'h088, 8'h0b);
    @(posedge clk);
    pins <= 2'h3;
    cyc(6);
    rdc(lo_a, 8'h30);
    wr(lo_a, 32'h0);
    @(posedge clk);
    pins <= 2'h2;
    cyc(6);
    rdc(lo_a, 8'h10);
    $display("test edge modes done");
    summarize;
  end
endmodule // vic_ctrl_tb_top
